/* File: verilog/hbr_port.sv */
// Processor access to the host controller's transfer buffer RAM.
// ==========================================================
// What the document requires of this block and the processor driving it
// R1 - Command 2D reads the first isochronous buffer's pending byte count.
// R2 - Command 2E reads the second isochronous buffer's pending byte count.
// R3 - Processor loads transfer counter with readback length before isochronous readback.
// R4 - Isochronous port word: even byte in bits 15:8, odd in 7:0.
// R5 - Isochronous port opens with 40 for read, C0 for write.
// R6 - Acknowledged port word: odd byte in bits 15:8, even in 7:0.
// R7 - Acknowledged port opens with 41 for read, C1 for write.
// R8 - Processor issues the port command once, then moves whole words.
// R9 - Processor programs the counter and checks status before any transfer.
// R10 - Each word access advances the buffer pointer by two until counter.
// R11 - Pointer reaching counter pulses end of transfer, sets done flag, status.
// R12 - RAM holds bytes; counter counts bytes; each access moves a word.
// R13 - Core clock is 48 MHz from a 6 MHz reference times eight.
// R14 - Status shows full and done flag for each of three buffers.
// R15 - Accepting a port command returns its pointer to the buffer start.
module hbr_port (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        srst,
    // Command strobe from the processor interface
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_code,
    // Write data words
    input  wire logic        wr_valid,
    output logic             wr_ready,
    input  wire logic [15:0] wr_word,
    // Read data words and register reads
    output logic             rd_valid,
    input  wire logic        rd_ready,
    output logic      [15:0] rd_word,
    // Values kept elsewhere in the controller
    input  wire logic [15:0] transfer_byte_counter,
    input  wire logic [15:0] iso_buffer_length,
    input  wire logic        iso_list_sel,
    input  wire logic [15:0] iso0_pending_byte_count,
    input  wire logic [15:0] iso1_pending_byte_count,
    input  wire logic        engine_done_iso0,
    input  wire logic        engine_done_iso1,
    input  wire logic        engine_done_ack,
    input  wire logic        status_clear,
    // Event and status outputs
    output logic             end_of_transfer,
    output logic             all_transfers_done_flag,
    output logic      [15:0] buffer_status_reg
);
    // ==========================================================
    // Storage and state
    logic [7:0]        ram [0:hbr_pkg::RAM_BYTES-1];
    hbr_pkg::hbr_state_e state;
    logic              on_ack;
    logic [15:0]       byte_ptr;
    logic              fetch_valid;
    logic [15:0]       fetch_word;
    logic              buf_ready;
    // The multiplied core rate is made outside this block; all logic here runs on clock alone,
    // so no slower enable is needed and no crossing between rates arises. [R13]

    // Address of one byte of the selected buffer; ack buffer follows both iso buffers.
    function automatic logic [11:0] byte_addr(input logic ack, input logic sel,
                                              input logic [15:0] base_len, input logic [15:0] off);
        logic [15:0] base;
        base = ack ? (base_len << 1) : (sel ? base_len : 16'h0000);
        byte_addr = 12'(base + off);
    endfunction

    // ==========================================================
    // Command decode.
    wire is_len0   = cmd_valid && (cmd_code == hbr_pkg::CMD_ISO0_LEN_RD);                        // [R1]
    wire is_len1   = cmd_valid && (cmd_code == hbr_pkg::CMD_ISO1_LEN_RD);                        // [R2]
    wire open_rd   = cmd_valid && (cmd_code == hbr_pkg::CMD_ISO_PORT_RD
                               || cmd_code == hbr_pkg::CMD_ACK_PORT_RD);                         // [R5] [R7]
    wire open_wr   = cmd_valid && (cmd_code == hbr_pkg::CMD_ISO_PORT_WR
                               || cmd_code == hbr_pkg::CMD_ACK_PORT_WR);                         // [R5] [R7]
    wire open_ack  = cmd_code[0];
    wire at_end    = (byte_ptr >= transfer_byte_counter);
    wire [15:0] next_ptr = byte_ptr + hbr_pkg::WORD_STEP;                                        // [R10]
    wire [11:0] a_even = byte_addr(on_ack, iso_list_sel, iso_buffer_length, byte_ptr);
    wire [11:0] a_odd  = byte_addr(on_ack, iso_list_sel, iso_buffer_length, byte_ptr + 16'h0001);
    wire step_rd   = (state == hbr_pkg::HBR_READ) && !at_end && buf_ready && !fetch_valid;
    wire step_wr   = (state == hbr_pkg::HBR_WRITE) && !at_end && wr_valid;
    wire step      = step_rd || step_wr;                                                         // [R12]
    wire finishing = step && (next_ptr >= transfer_byte_counter);                                // [R11]

    assign wr_ready = (state == hbr_pkg::HBR_WRITE) && !at_end;

    // Read words go through the two-entry buffer so a stalled reader loses nothing.
    hbr_skid hbr_skid_inst (
        .clock     (clock),
        .srst      (srst),
        .in_valid  (fetch_valid),
        .in_ready  (buf_ready),
        .in_data   (fetch_word),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_word)
    );

    // Port state, pointer reset on every accepted port open command; 2D and 2E return the state to idle and leave the pointer alone.
    always_ff @(posedge clock) begin
        if (srst) begin
            state    <= hbr_pkg::HBR_IDLE;
            on_ack   <= 1'b0;
            byte_ptr <= 16'h0000;
        end else if (open_rd || open_wr) begin
            state    <= open_rd ? hbr_pkg::HBR_READ : hbr_pkg::HBR_WRITE;
            on_ack   <= open_ack;
            byte_ptr <= 16'h0000;                                                                // [R15]
        end else if (is_len0 || is_len1) begin
            state    <= hbr_pkg::HBR_IDLE;
        end else if (step) begin
            byte_ptr <= next_ptr;                                                                // [R10]
        end
    end

    // Fetch stage: one word per read step, or a length register on 2D and 2E.
    always_ff @(posedge clock) begin
        if (srst) begin
            fetch_valid <= 1'b0;
            fetch_word  <= hbr_pkg::RST_WORD;
        end else if (fetch_valid && buf_ready) begin
            fetch_valid <= 1'b0;
        end else if (is_len0 || is_len1) begin
            fetch_valid <= 1'b1;
            fetch_word  <= is_len0 ? iso0_pending_byte_count : iso1_pending_byte_count;          // [R1] [R2]
        end else if (step_rd) begin
            fetch_valid <= 1'b1;
            fetch_word  <= on_ack ? {ram[a_odd], ram[a_even]}                                    // [R6]
                                  : {ram[a_even], ram[a_odd]};                                   // [R4]
        end
    end

    // RAM write with the same lane order as the read.
    always_ff @(posedge clock) begin
        if (step_wr) begin
            ram[a_even] <= on_ack ? wr_word[7:0] : wr_word[15:8];                                // [R4] [R6]
            ram[a_odd]  <= on_ack ? wr_word[15:8] : wr_word[7:0];                                // [R4] [R6]
        end
    end

    // Event pulse and sticky flags; a set in the clearing cycle wins.
    wire [2:0] done_set = {engine_done_ack, engine_done_iso1, engine_done_iso0}; // Engine reads only. [R14]
    always_ff @(posedge clock) begin
        if (srst) begin
            end_of_transfer         <= 1'b0;
            all_transfers_done_flag <= 1'b0;
            buffer_status_reg       <= hbr_pkg::RST_STATUS;
        end else begin
            end_of_transfer         <= finishing;                                                // [R11]
            all_transfers_done_flag <= finishing || (all_transfers_done_flag && !status_clear);  // [R11]
            if (status_clear)
                buffer_status_reg <= hbr_pkg::RST_STATUS;
            buffer_status_reg[hbr_pkg::STAT_ISO0_DONE] <= done_set[0]
                || (buffer_status_reg[hbr_pkg::STAT_ISO0_DONE] && !status_clear);                // [R14]
            buffer_status_reg[hbr_pkg::STAT_ISO1_DONE] <= done_set[1]
                || (buffer_status_reg[hbr_pkg::STAT_ISO1_DONE] && !status_clear);                // [R14]
            buffer_status_reg[hbr_pkg::STAT_ACK_DONE]  <= done_set[2]
                || (buffer_status_reg[hbr_pkg::STAT_ACK_DONE] && !status_clear);                 // [R14]
            if (finishing) begin
                // Write fills the buffer; a completed read empties it.
                if (on_ack)
                    buffer_status_reg[hbr_pkg::STAT_ACK_FULL] <= (state == hbr_pkg::HBR_WRITE);  // [R11]
                else if (iso_list_sel)
                    buffer_status_reg[hbr_pkg::STAT_ISO1_FULL] <= (state == hbr_pkg::HBR_WRITE); // [R11]
                else
                    buffer_status_reg[hbr_pkg::STAT_ISO0_FULL] <= (state == hbr_pkg::HBR_WRITE); // [R11]
            end
        end
    end

    // ==========================================================
    // Checks on the pointer, the event and the register reads.
    chk_step_by_two: assert property (@(posedge clock) disable iff (srst) // [R10]
        step && !cmd_valid |=> byte_ptr == $past(byte_ptr) + 16'h0002) else $error("pointer step wrong");
    chk_reopen_zero: assert property (@(posedge clock) disable iff (srst) // [R15]
        open_rd || open_wr |=> byte_ptr == 16'h0000) else $error("pointer not reset");
    chk_eot_pulse: assert property (@(posedge clock) disable iff (srst) // [R11]
        finishing |=> end_of_transfer && all_transfers_done_flag) else $error("end of transfer missing");
    chk_no_eot: assert property (@(posedge clock) disable iff (srst) // [R11]
        !finishing |=> !end_of_transfer) else $error("spurious end of transfer");
    chk_len0_read: assert property (@(posedge clock) disable iff (srst) // [R1]
        is_len0 && !fetch_valid |=> fetch_valid && fetch_word == $past(iso0_pending_byte_count))
        else $error("length 0 wrong");
    chk_len1_read: assert property (@(posedge clock) disable iff (srst) // [R2]
        is_len1 && !fetch_valid |=> fetch_valid && fetch_word == $past(iso1_pending_byte_count))
        else $error("length 1 wrong");
    // Lane order is checked on the whole word, so a swapped pair cannot hide in the other half.
    chk_iso_lanes: assert property (@(posedge clock) disable iff (srst) // [R4]
        step_rd && !on_ack && !cmd_valid |=> fetch_word == {$past(ram[a_even]), $past(ram[a_odd])})
        else $error("iso lane order");
    chk_ack_lanes: assert property (@(posedge clock) disable iff (srst) // [R6]
        step_rd && on_ack && !cmd_valid |=> fetch_word == {$past(ram[a_odd]), $past(ram[a_even])})
        else $error("ack lane order");
    // After the final word the port must refuse more, as long as no command arrives in that cycle.
    chk_stop_at_end: assert property (@(posedge clock) disable iff (srst) // [R10]
        finishing && !cmd_valid |=> at_end && !wr_ready) else $error("port open past counter");
    chk_no_fetch_end: assert property (@(posedge clock) disable iff (srst) // [R10]
        state == hbr_pkg::HBR_READ && at_end && !cmd_valid && !fetch_valid |=> !fetch_valid)
        else $error("word fetched past counter");

    // ==========================================================
    // Opening a port takes two steps: the command edge, then the armed state with the pointer at zero.
    sequence s_read_cmd;
        cmd_valid && (cmd_code == hbr_pkg::CMD_ISO_PORT_RD || cmd_code == hbr_pkg::CMD_ACK_PORT_RD);
    endsequence
    sequence s_read_armed;
        state == hbr_pkg::HBR_READ && byte_ptr == 16'h0000;
    endsequence
    sequence s_write_cmd;
        cmd_valid && (cmd_code == hbr_pkg::CMD_ISO_PORT_WR || cmd_code == hbr_pkg::CMD_ACK_PORT_WR);
    endsequence
    sequence s_write_armed;
        state == hbr_pkg::HBR_WRITE && byte_ptr == 16'h0000;
    endsequence
    chk_read_opens: assert property (@(posedge clock) disable iff (srst) // [R5] [R7] [R15]
        s_read_cmd |=> s_read_armed) else $error("read port not opened");
    chk_write_opens: assert property (@(posedge clock) disable iff (srst) // [R5] [R7] [R15]
        s_write_cmd |=> s_write_armed) else $error("write port not opened");

    // ==========================================================
    // The flag and the done bits sticky until cleared, the full bits set by a write and cleared by a read; each set only by its own events.
    chk_flag_sticky: assert property (@(posedge clock) disable iff (srst) // [R11]
        all_transfers_done_flag && !status_clear |=> all_transfers_done_flag) else $error("done flag dropped");
    chk_flag_clear: assert property (@(posedge clock) disable iff (srst) // [R11]
        status_clear && !finishing |=> !all_transfers_done_flag) else $error("done flag not cleared");
    chk_iso0_done: assert property (@(posedge clock) disable iff (srst) // [R14]
        engine_done_iso0 |=> buffer_status_reg[hbr_pkg::STAT_ISO0_DONE]) else $error("iso0 done not set");
    chk_ack_done_source: assert property (@(posedge clock) disable iff (srst) // [R14]
        !engine_done_ack && !buffer_status_reg[hbr_pkg::STAT_ACK_DONE]
        |=> !buffer_status_reg[hbr_pkg::STAT_ACK_DONE]) else $error("ack done set without engine read");
    chk_full_on_write: assert property (@(posedge clock) disable iff (srst) // [R11] [R14]
        finishing && state == hbr_pkg::HBR_WRITE && on_ack |=> buffer_status_reg[hbr_pkg::STAT_ACK_FULL])
        else $error("ack full not set");
    chk_empty_on_read: assert property (@(posedge clock) disable iff (srst) // [R11] [R14]
        finishing && state == hbr_pkg::HBR_READ && !on_ack && !iso_list_sel
        |=> !buffer_status_reg[hbr_pkg::STAT_ISO0_FULL]) else $error("iso0 full not cleared");
    // A stalled reader must see the same word until it takes it.
    chk_word_holds: assert property (@(posedge clock) disable iff (srst) // [R12]
        rd_valid && !rd_ready |=> rd_valid && rd_word == $past(rd_word)) else $error("read word lost");
endmodule

/* File: inc/hbr_pkg.sv */
// Package of command codes, field positions and reset values for the buffer RAM access port.
package hbr_pkg;
    // ==========================================================
    // Command codes
    localparam logic [7:0] CMD_ISO0_LEN_RD = 8'h2D;
    localparam logic [7:0] CMD_ISO1_LEN_RD = 8'h2E;
    localparam logic [7:0] CMD_ISO_PORT_RD = 8'h40;
    localparam logic [7:0] CMD_ACK_PORT_RD = 8'h41;
    localparam logic [7:0] CMD_ISO_PORT_WR = 8'hC0;
    localparam logic [7:0] CMD_ACK_PORT_WR = 8'hC1;
    // ==========================================================
    // Sizes and field positions
    localparam int          RAM_BYTES      = 4096;
    localparam int          ADDR_W         = 12;
    localparam logic [15:0] WORD_STEP      = 16'h0002;
    localparam int          ALL_DONE_BIT   = 2;
    localparam int          STAT_ISO0_FULL = 0;
    localparam int          STAT_ISO1_FULL = 1;
    localparam int          STAT_ACK_FULL  = 2;
    localparam int          STAT_ISO0_DONE = 3;
    localparam int          STAT_ISO1_DONE = 4;
    localparam int          STAT_ACK_DONE  = 5;
    localparam logic [15:0] RST_WORD       = 16'h0000;
    localparam logic [15:0] RST_STATUS     = 16'h0000;
    // ==========================================================
    // Clock figures: 6 MHz reference multiplied by eight to 48 MHz.
    localparam int REF_MHZ  = 6;
    localparam int CORE_MHZ = 48;
    localparam int CLK_MHZ  = 250;
    // Port state.
    typedef enum logic [1:0] {HBR_IDLE, HBR_READ, HBR_WRITE} hbr_state_e;
endpackage

/* File: verilog/hbr_skid.sv */
// Two-entry buffer with valid and ready on both sides.
module hbr_skid (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        srst,
    // Filling side
    input  wire logic        in_valid,
    output logic             in_ready,
    input  wire logic [15:0] in_data,
    // Draining side
    output logic             out_valid,
    input  wire logic        out_ready,
    output logic      [15:0] out_data
);
    logic [15:0] mem [0:1];
    logic        wr_ptr;
    logic        rd_ptr;
    logic [1:0]  count;
    wire         push = in_valid && in_ready;
    wire         pop  = out_valid && out_ready;

    // Full and empty come straight from the occupancy count.
    assign in_ready  = (count != 2'd2);
    assign out_valid = (count != 2'd0);
    assign out_data  = mem[rd_ptr];

    // Pointers and count; entries need no reset since count guards them.
    always_ff @(posedge clock) begin
        if (srst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'd0;
        end else begin
            if (push) begin
                mem[wr_ptr] <= in_data;
                wr_ptr      <= ~wr_ptr;
            end
            if (pop)
                rd_ptr <= ~rd_ptr;
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

/* File: test/hbr_cpu_model.sv */
// Processor model that drains read words from the buffer RAM access port.
module hbr_cpu_model (
    // Clock
    input  wire logic        clock,
    // Pacing choice from the bench
    input  wire logic        slow,
    // Read word handshake
    input  wire logic        rd_valid,
    output logic             rd_ready,
    input  wire logic [15:0] rd_word,
    // Words handed to the bench
    output logic             taken,
    output logic      [15:0] taken_word
);
    timeunit 1ns;
    timeprecision 1ps;
    logic phase = 1'b0;
    // ==========================================================
    // A slow processor accepts only every other cycle, so the two-entry buffer has to hold words.
    assign rd_ready = !slow || phase;
    // Each accepted handshake takes one whole 16-bit word.
    always_ff @(posedge clock) begin
        phase      <= !phase;
        taken      <= rd_valid && rd_ready;
        taken_word <= rd_word;
    end
endmodule

/* File: test/hbr_port_test.sv */
// Self-checking testbench for the buffer RAM access port.
module hbr_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0, srst = 1'b1, cmd_valid = 1'b0, wr_valid = 1'b0, slow = 1'b0;
    logic        iso_list_sel = 1'b0, status_clear = 1'b0;
    logic        engine_done_iso0 = 1'b0, engine_done_iso1 = 1'b0, engine_done_ack = 1'b0;
    logic [7:0]  cmd_code = 8'h00;
    logic [15:0] wr_word = 16'h0000, transfer_byte_counter = 16'h0000, iso_buffer_length = 16'h0000;
    logic [15:0] iso0_pending_byte_count = 16'h0004, iso1_pending_byte_count = 16'h0A5C;
    logic        wr_ready, rd_valid, rd_ready, end_of_transfer, all_transfers_done_flag, taken;
    logic [15:0] rd_word, buffer_status_reg, taken_word, got;
    int          errors = 0, n_checks = 0, n_eot = 0;
    // ==========================================================
    // Design and processor model.
    hbr_port hbr_port_inst (.clock(clock), .srst(srst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word), .rd_valid(rd_valid), .rd_ready(rd_ready),
        .rd_word(rd_word), .transfer_byte_counter(transfer_byte_counter), .iso_buffer_length(iso_buffer_length),
        .iso_list_sel(iso_list_sel), .iso0_pending_byte_count(iso0_pending_byte_count),
        .iso1_pending_byte_count(iso1_pending_byte_count), .engine_done_iso0(engine_done_iso0),
        .engine_done_iso1(engine_done_iso1), .engine_done_ack(engine_done_ack), .status_clear(status_clear),
        .end_of_transfer(end_of_transfer), .all_transfers_done_flag(all_transfers_done_flag),
        .buffer_status_reg(buffer_status_reg));
    hbr_cpu_model hbr_cpu_model_inst (.clock(clock), .slow(slow), .rd_valid(rd_valid), .rd_ready(rd_ready),
        .rd_word(rd_word), .taken(taken), .taken_word(taken_word));
    // ==========================================================
    // Clock, and a count of end-of-transfer pulses sampled where they are settled.
    initial forever #2 clock = ~clock;
    always @(negedge clock) if (end_of_transfer === 1'b1) n_eot++;
    // ==========================================================
    // Comparison, verdict and access tasks.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        if (errors == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Called just after a rising edge; returns at the edge that took the command.
    task automatic send_cmd(input logic [7:0] code);
        cmd_valid <= 1'b1;
        cmd_code  <= code;
        @(posedge clock);
        cmd_valid <= 1'b0;
    endtask
    // Holds the word until the edge that takes it; wr_valid stays up for a following word.
    task automatic put(input logic [15:0] w);
        int n = 0;
        wr_valid <= 1'b1;
        wr_word  <= w;
        do begin @(negedge clock); n++; end while (wr_ready !== 1'b1 && n < 40);
        check({15'h0000, wr_ready}, 16'h0001);
        @(posedge clock);
    endtask
    task automatic get(output logic [15:0] w);
        int n = 0;
        do begin @(negedge clock); n++; end while (taken !== 1'b1 && n < 40);
        check({15'h0000, taken}, 16'h0001);
        w = taken_word;
    endtask
    // Opens a port once, moves two words and expects exactly one end-of-transfer pulse.
    task automatic xfer(input logic [7:0] code, input logic [15:0] w0, w1, input logic rd);
        logic [15:0] g;
        int          eot0 = n_eot;
        send_cmd(code);
        if (rd) begin
            get(g);
            check(g, w0);
            get(g);
            check(g, w1);
        end else begin
            put(w0);
            put(w1);
            wr_valid <= 1'b0;
        end
        repeat (3) @(posedge clock);
        check(16'(n_eot - eot0), 16'h0001);
    endtask
    // ==========================================================
    // Main sequence: the iso buffer length of zero puts every buffer at address zero,
    // so a word written through one port can be read back through the other.
    initial begin
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        check(buffer_status_reg, hbr_pkg::RST_STATUS);
        check({15'h0000, all_transfers_done_flag}, 16'h0000);
        send_cmd(hbr_pkg::CMD_ISO0_LEN_RD);
        get(got);
        check(got, 16'h0004);
        @(posedge clock);
        transfer_byte_counter <= got;
        send_cmd(hbr_pkg::CMD_ISO1_LEN_RD);
        get(got);
        check(got, 16'h0A5C);
        @(posedge clock);
        check(buffer_status_reg, 16'h0000);
        xfer(hbr_pkg::CMD_ISO_PORT_WR, 16'hA1B2, 16'hC3D4, 1'b0);
        check({15'h0000, wr_ready}, 16'h0000);
        check(buffer_status_reg, 16'h0001);
        check({15'h0000, all_transfers_done_flag}, 16'h0001);
        slow <= 1'b1;
        xfer(hbr_pkg::CMD_ACK_PORT_RD, 16'hB2A1, 16'hD4C3, 1'b1);
        status_clear <= 1'b1;
        @(posedge clock);
        status_clear <= 1'b0;
        slow         <= 1'b0;
        @(posedge clock);
        check(buffer_status_reg, 16'h0000);
        check({15'h0000, all_transfers_done_flag}, 16'h0000);
        xfer(hbr_pkg::CMD_ACK_PORT_WR, 16'h5A6B, 16'h7C8D, 1'b0);
        check(buffer_status_reg, 16'h0004);
        xfer(hbr_pkg::CMD_ISO_PORT_RD, 16'h6B5A, 16'h8D7C, 1'b1);
        engine_done_iso0 <= 1'b1;
        engine_done_iso1 <= 1'b1;
        engine_done_ack  <= 1'b1;
        @(posedge clock);
        engine_done_iso0 <= 1'b0;
        engine_done_iso1 <= 1'b0;
        engine_done_ack  <= 1'b0;
        @(posedge clock);
        check(buffer_status_reg, 16'h003C);
        // Second iso buffer at byte 16: its words must land apart from the first buffer's.
        iso_list_sel      <= 1'b1;
        iso_buffer_length <= 16'h0010;
        xfer(hbr_pkg::CMD_ISO_PORT_WR, 16'h1122, 16'h3344, 1'b0);
        check(buffer_status_reg, 16'h003E);
        xfer(hbr_pkg::CMD_ISO_PORT_RD, 16'h1122, 16'h3344, 1'b1);
        check(buffer_status_reg, 16'h003C);
        iso_list_sel <= 1'b0;
        xfer(hbr_pkg::CMD_ISO_PORT_RD, 16'h6B5A, 16'h8D7C, 1'b1);
        complete_run;
    end
    // ==========================================================
    // Watchdog: the sequence needs under a hundred cycles, so this limit means a hang.
    initial begin
        repeat (5000) @(posedge clock);
        errors++;
        complete_run;
    end
endmodule
